// ==== src/pic_pkg.sv ====
// Constants, register map and types of the prioritized interrupt controller
package pic_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T128_NS       = 128_000;
  localparam int unsigned T1MS_NS       = 1_024_000;
  localparam int unsigned WAKE_NS       = 1_000_000;
  localparam int unsigned BR_LONG_NS    = 256_000;

  localparam logic [15:0] T128_CYC    = 16'(T128_NS / CLK_PERIOD_NS);
  localparam logic [15:0] T1MS_CYC    = 16'(T1MS_NS / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_CYC    = 16'(WAKE_NS / CLK_PERIOD_NS);
  localparam logic [1:0]  BR_TICKS    = 2'(BR_LONG_NS / T128_NS);
  localparam logic [3:0]  CALL_CYCLES = 4'h0 + 4'(10);
  localparam logic [3:0]  JMP_CYCLES  = 4'h0 + 4'(5);

  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE  = 16'h0002;
  localparam logic [15:0] VEC_STEP  = 16'h0002;
  localparam int unsigned NUM_VEC   = 11;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GPEN0   = 8'h04;
  localparam logic [7:0] IDX_GPEN1   = 8'h05;
  localparam logic [7:0] IDX_GPOL0   = 8'h06;
  localparam logic [7:0] IDX_GPOL1   = 8'h07;
  localparam logic [7:0] IDX_GSE     = 8'h20;
  localparam logic [7:0] IDX_EPE     = 8'h21;
  localparam logic [7:0] IDX_PEND_LO = 8'h22;
  localparam logic [7:0] IDX_PEND_HI = 8'h23;
  localparam logic [7:0] IDX_CTRL    = 8'h24;
  localparam logic [7:0] IDX_SPI     = 8'h25;
  localparam logic [7:0] IDX_STAT    = 8'h26;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // Global source enable bit positions
  localparam int unsigned GSE_BUS  = 0;
  localparam int unsigned GSE_T128 = 1;
  localparam int unsigned GSE_T1MS = 2;
  localparam int unsigned GSE_SPI  = 3;
  localparam int unsigned GSE_CAPA = 4;
  localparam int unsigned GSE_CAPB = 5;
  localparam int unsigned GSE_GPIO = 6;
  localparam int unsigned GSE_WAKE = 7;

  // Pending index = vector number minus one
  localparam int unsigned P_BUS  = 0;
  localparam int unsigned P_T128 = 1;
  localparam int unsigned P_T1MS = 2;
  localparam int unsigned P_EP0  = 3;
  localparam int unsigned P_SPI  = 6;
  localparam int unsigned P_CAPA = 7;
  localparam int unsigned P_CAPB = 8;
  localparam int unsigned P_GPIO = 9;
  localparam int unsigned P_WAKE = 10;

  // Control register fields
  localparam int unsigned CTRL_MODE   = 0;
  localparam int unsigned CTRL_A_RISE = 1;
  localparam int unsigned CTRL_A_FALL = 2;
  localparam int unsigned CTRL_B_RISE = 3;
  localparam int unsigned CTRL_B_FALL = 4;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_CALL = 2'b01,
    PIC_JUMP = 2'b10
  } pic_seq_t;

endpackage : pic_pkg

// ==== src/pic_tick_if.sv ====
// Run request and tick pulse between the controller and a periodic timer
`timescale 1ns/1ps
`default_nettype none
interface pic_tick_if;
  logic run;
  logic tick;
  modport timer (input run, output tick);
  modport user  (output run, input tick);
endinterface : pic_tick_if
`default_nettype wire

// ==== src/pic_tick.sv ====
// Periodic tick generator, cleared and stopped while not running
`timescale 1ns/1ps
`default_nettype none
module pic_tick
  import pic_pkg::*;
#(
  parameter logic [15:0] PERIOD = T128_CYC
) (
  input wire logic   core_clk,
  input wire logic   rst_b,
  pic_tick_if.timer  tk
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } pic_tick_state_t;

  pic_tick_state_t s_reg;
  pic_tick_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (!tk.run) begin
      s_next.cnt = 16'h0000;
    end else if (s_reg.cnt == PERIOD - 16'h0001) begin
      s_next.cnt  = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tk.tick = s_reg.tick;

endmodule : pic_tick
`default_nettype wire

// ==== src/pic_ctrl.sv ====
// Prioritized interrupt controller top with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl
  import pic_pkg::*;
#(
  parameter logic [15:0] T128_CYCLES = T128_CYC,
  parameter logic [15:0] T1MS_CYCLES = T1MS_CYC,
  parameter logic [15:0] WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [9:0]  avs_address,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        cpu_instr_done,
  input  wire logic        cpu_ei,
  input  wire logic        cpu_di,
  input  wire logic        cpu_reti,
  output logic             cpu_busy,
  output logic             cpu_global_ie,
  output logic             cpu_irq_pending,
  output logic      [15:0] cpu_fetch_addr,
  output logic             cpu_vector_call,
  output logic             cpu_isr_start,
  input  wire logic [15:0] gpio_pin,
  input  wire logic        cap_a_pin,
  input  wire logic        cap_b_pin,
  input  wire logic        spi_byte_done,
  input  wire logic [7:0]  spi_rx_byte,
  output logic             transfer_complete_flag,
  input  wire logic [2:0]  ep_event,
  input  wire logic        usb_dp,
  input  wire logic        usb_dm,
  input  wire logic        ps2_serial_data_line,
  output logic             usb_addr_clear
);

  typedef struct packed {
    logic [7:0]  gse;
    logic [2:0]  epe;
    logic [15:0] gpen;
    logic [15:0] gpol;
    logic [4:0]  ctrl;
    logic [10:0] pend;
    logic        gie;
    logic [15:0] gpio_prev;
    logic [15:0] gpio_hold;
    logic [1:0]  cap_prev;
    logic [1:0]  br_cnt;
    logic        br_long;
    logic        tcf;
    logic [7:0]  spi_data;
    logic        rd_ack;
    logic [31:0] rdata;
    pic_seq_t    state;
    logic [3:0]  cyc;
    logic [3:0]  svc;
    logic [15:0] fetch_addr;
    logic        call_pulse;
    logic        isr_pulse;
  } pic_state_t;

  localparam pic_state_t ST_RST = '{fetch_addr: VEC_RESET, state: PIC_IDLE, default: '0};

  pic_state_t  s_reg;
  pic_state_t  s_next;

  pic_tick_if  t128_if ();
  pic_tick_if  t1ms_if ();
  pic_tick_if  wake_if ();

  logic [7:0]  widx;
  logic [7:0]  wbyte;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] gpio_act;
  logic [15:0] gpio_prev_act;
  logic [15:0] gpio_edge;
  logic        gpio_fire;
  logic        a_rise;
  logic        a_fall;
  logic        b_rise;
  logic        b_fall;
  logic        fire_a;
  logic        fire_b;
  logic        br_cond;
  logic [1:0]  br_cnt_n;
  logic        br_long_n;
  logic        usb_fire;
  logic        ps2_fire;
  logic [10:0] set_v;
  logic [10:0] en_v;
  logic [10:0] req_v;
  logic [10:0] clr_v;
  logic [3:0]  sel;
  logic        take;
  logic [7:0]  rbyte;

  // The 128 us and 1 ms timers always count and only their pending set is gated by enables; the wake timer runs only while GSE_WAKE is set
  assign t128_if.run = 1'b1;
  assign t1ms_if.run = 1'b1;
  assign wake_if.run = s_reg.gse[GSE_WAKE];

  pic_tick #(.PERIOD(T128_CYCLES)) u_t128 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tk       (t128_if)
  );

  pic_tick #(.PERIOD(T1MS_CYCLES)) u_t1ms (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tk       (t1ms_if)
  );

  pic_tick #(.PERIOD(WAKE_CYCLES)) u_wake (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tk       (wake_if)
  );

  always_comb begin
    s_next            = s_reg;
    s_next.call_pulse = 1'b0;
    s_next.isr_pulse  = 1'b0;

    widx   = avs_address[9:2];
    wbyte  = avs_writedata[7:0];
    wr_hit = avs_write & avs_byteenable[0] & (avs_address[1:0] == 2'b00);
    rd_hit = avs_read & ~s_reg.rd_ack & (avs_address[1:0] == 2'b00);

    // GPIO: a pin is active at its trigger level; edges only count when enabled
    gpio_act      = (s_reg.gpol & gpio_pin) | (~s_reg.gpol & ~gpio_pin);
    gpio_prev_act = (s_reg.gpol & s_reg.gpio_prev) | (~s_reg.gpol & ~s_reg.gpio_prev);
    gpio_edge     = gpio_act & ~gpio_prev_act & s_reg.gpen;
    // Held pins block every other pin; no pin outranks another
    gpio_fire = (|gpio_edge) & ~(|s_reg.gpio_hold) & s_reg.gse[GSE_GPIO];
    s_next.gpio_hold = (s_reg.gpio_hold & gpio_act & s_reg.gpen)
                     | (gpio_fire ? gpio_edge : 16'h0000);
    s_next.gpio_prev = gpio_pin;

    // Capture pins use their own edge selects, outside the GPIO path
    a_rise = cap_a_pin & ~s_reg.cap_prev[0];
    a_fall = ~cap_a_pin & s_reg.cap_prev[0];
    b_rise = cap_b_pin & ~s_reg.cap_prev[1];
    b_fall = ~cap_b_pin & s_reg.cap_prev[1];
    fire_a = (a_rise & s_reg.ctrl[CTRL_A_RISE]) | (a_fall & s_reg.ctrl[CTRL_A_FALL]);
    fire_b = (b_rise & s_reg.ctrl[CTRL_B_RISE]) | (b_fall & s_reg.ctrl[CTRL_B_FALL]);
    s_next.cap_prev = {cap_b_pin, cap_a_pin};

    // Condition counted in 128 us ticks, so it is long after 128 to 256 us
    br_cond = s_reg.ctrl[CTRL_MODE] ? ~ps2_serial_data_line : (~usb_dp & ~usb_dm);
    if (!br_cond) begin
      br_cnt_n = 2'b00;
    end else if (t128_if.tick && s_reg.br_cnt != BR_TICKS) begin
      br_cnt_n = s_reg.br_cnt + 2'b01;
    end else begin
      br_cnt_n = s_reg.br_cnt;
    end
    br_long_n      = br_cond & (br_cnt_n == BR_TICKS);
    s_next.br_cnt  = br_cnt_n;
    s_next.br_long = br_long_n;
    // USB fires when a long SE0 ends; the end is seen within one cycle, well inside 128 us
    usb_fire = ~s_reg.ctrl[CTRL_MODE] & s_reg.br_long & ~br_cond;
    ps2_fire = s_reg.ctrl[CTRL_MODE] & br_long_n & ~s_reg.br_long;

    set_v          = '0;
    set_v[P_BUS]   = usb_fire | ps2_fire;
    set_v[P_T128]  = t128_if.tick & s_reg.gse[GSE_T128];
    set_v[P_T1MS]  = t1ms_if.tick & s_reg.gse[GSE_T1MS];
    set_v[5:3]     = ep_event;
    set_v[P_SPI]   = spi_byte_done;
    set_v[P_CAPA]  = fire_a;
    set_v[P_CAPB]  = fire_b;
    set_v[P_GPIO]  = gpio_fire;
    set_v[P_WAKE]  = wake_if.tick;

    en_v = {s_reg.gse[GSE_WAKE], s_reg.gse[GSE_GPIO], s_reg.gse[GSE_CAPB],
            s_reg.gse[GSE_CAPA], s_reg.gse[GSE_SPI], s_reg.epe,
            s_reg.gse[GSE_T1MS], s_reg.gse[GSE_T128], s_reg.gse[GSE_BUS]};
    req_v = s_reg.pend & en_v;

    // Downward scan leaves the lowest requesting vector selected
    sel = 4'h0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req_v[i]) begin
        sel = 4'(i);
      end
    end
    take  = cpu_instr_done & s_reg.gie & (s_reg.state == PIC_IDLE) & (|req_v);
    clr_v = take ? (11'h001 << sel) : 11'h000;
    // A new event in the acknowledge cycle stays pending
    s_next.pend = set_v | (s_reg.pend & ~clr_v);

    if (take) begin
      s_next.gie = 1'b0;
    end else if (cpu_di) begin
      s_next.gie = 1'b0;
    end else if (cpu_ei || cpu_reti) begin
      s_next.gie = 1'b1;
    end

    unique case (s_reg.state)
      PIC_IDLE: begin
        if (take) begin
          s_next.state = PIC_CALL;
          s_next.cyc   = CALL_CYCLES - 4'h1;
          s_next.svc   = sel;
        end
      end
      PIC_CALL: begin
        if (s_reg.cyc == 4'h0) begin
          s_next.state      = PIC_JUMP;
          s_next.cyc        = JMP_CYCLES - 4'h1;
          s_next.fetch_addr = VEC_BASE + VEC_STEP * {12'h000, s_reg.svc};
          s_next.call_pulse = 1'b1;
        end else begin
          s_next.cyc = s_reg.cyc - 4'h1;
        end
      end
      PIC_JUMP: begin
        if (s_reg.cyc == 4'h0) begin
          s_next.state     = PIC_IDLE;
          s_next.isr_pulse = 1'b1;
        end else begin
          s_next.cyc = s_reg.cyc - 4'h1;
        end
      end
      default: begin
        s_next.state = PIC_IDLE;
      end
    endcase

    if (spi_byte_done) begin
      s_next.spi_data = spi_rx_byte;
      s_next.tcf      = 1'b1;
    end else if (rd_hit && widx == IDX_SPI) begin
      s_next.tcf = 1'b0;
    end

    if (wr_hit) begin
      unique case (widx)
        IDX_GPEN0: s_next.gpen[7:0]  = wbyte;
        IDX_GPEN1: s_next.gpen[15:8] = wbyte;
        IDX_GPOL0: s_next.gpol[7:0]  = wbyte;
        IDX_GPOL1: s_next.gpol[15:8] = wbyte;
        IDX_GSE:   s_next.gse        = wbyte;
        IDX_EPE:   s_next.epe        = wbyte[2:0];
        IDX_CTRL:  s_next.ctrl       = wbyte[4:0];
        default: begin
        end
      endcase
    end

    unique case (widx)
      IDX_GSE:     rbyte = s_reg.gse;
      IDX_EPE:     rbyte = {5'h00, s_reg.epe};
      IDX_PEND_LO: rbyte = s_reg.pend[7:0];
      IDX_PEND_HI: rbyte = {5'h00, s_reg.pend[10:8]};
      IDX_CTRL:    rbyte = {3'h0, s_reg.ctrl};
      IDX_SPI:     rbyte = s_reg.spi_data;
      IDX_STAT:    rbyte = {4'h0, |req_v, s_reg.br_long, s_reg.gie, s_reg.tcf};
      default:     rbyte = RST_BYTE;
    endcase
    s_next.rd_ack = avs_read & ~s_reg.rd_ack;
    if (avs_read && !s_reg.rd_ack) begin
      s_next.rdata = {24'h00_0000, (avs_address[1:0] == 2'b00) ? rbyte : RST_BYTE};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata           = s_reg.rdata;
  assign avs_waitrequest        = avs_read & ~s_reg.rd_ack;
  assign cpu_busy               = (s_reg.state != PIC_IDLE);
  assign cpu_global_ie          = s_reg.gie;
  assign cpu_irq_pending        = |req_v;
  assign cpu_fetch_addr         = s_reg.fetch_addr;
  assign cpu_vector_call        = s_reg.call_pulse;
  assign cpu_isr_start          = s_reg.isr_pulse;
  assign transfer_complete_flag = s_reg.tcf;
  assign usb_addr_clear         = s_reg.br_long;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // The take cycle itself plus ten call cycles come before the call pulse is visible
  sequence call_phase_s;
    ##11 s_reg.call_pulse;
  endsequence

  sequence jump_phase_s;
    ##5 s_reg.isr_pulse;
  endsequence

  prio_lowest_a: assert property (
    take |-> (req_v & ((11'h001 << sel) - 11'h001)) == 11'h000 && req_v[sel])
    else $error("serviced vector is not the lowest requesting one");

  vec_slot_a: assert property (
    s_reg.call_pulse |-> s_reg.fetch_addr == 16'h0002 + {11'h000, s_reg.svc, 1'b0})
    else $error("vector address does not match serviced source");

  no_fetch_early_a: assert property (
    (s_reg.state == PIC_IDLE && !s_reg.call_pulse && $past(s_reg.fetch_addr) == VEC_RESET
     && !$past(s_reg.call_pulse)) |-> s_reg.fetch_addr == VEC_RESET)
    else $error("fetch address left the reset slot without a call");

  call_latency_a: assert property (
    take |-> call_phase_s ##0 jump_phase_s)
    else $error("call plus jump latency is not 10 plus 5 cycles");

  ack_clears_a: assert property (
    take |=> !s_reg.gie && !(s_reg.pend[s_reg.svc] && !$past(set_v[sel])))
    else $error("acknowledge did not clear global enable and pending flag");

  wake_stop_a: assert property (
    !s_reg.gse[GSE_WAKE] ##1 !s_reg.gse[GSE_WAKE] |-> !wake_if.tick)
    else $error("wake timer ticks while disabled");

  gpio_gate_a: assert property (
    $rose(s_reg.pend[P_GPIO]) |-> $past(s_reg.gse[GSE_GPIO]) && $past(s_reg.gpen) != 16'h0000)
    else $error("GPIO interrupt without pin and global enable");

  gpio_block_a: assert property (
    (|s_reg.gpio_hold) |-> !gpio_fire)
    else $error("second pin raised GPIO interrupt while one is held");

  pin_enable_keep_a: assert property (
    (take && !avs_write) |=> s_reg.gpen == $past(s_reg.gpen))
    else $error("acknowledge changed pin enables");

  spi_done_a: assert property (
    spi_byte_done |=> s_reg.tcf && s_reg.spi_data == $past(spi_rx_byte) && s_reg.pend[P_SPI])
    else $error("SPI byte done did not flag, latch and pend");

  ps2_fire_a: assert property (
    (s_reg.ctrl[CTRL_MODE] && $rose(s_reg.br_long)) |-> s_reg.pend[P_BUS])
    else $error("PS/2 long low did not pend vector 1 at once");

  usb_end_a: assert property (
    (!s_reg.ctrl[CTRL_MODE] && !$past(s_reg.ctrl[CTRL_MODE]) && $fell(s_reg.br_long)
     && !$past(br_cond)) |-> s_reg.pend[P_BUS])
    else $error("end of long SE0 did not pend vector 1");

endmodule : pic_ctrl
`default_nettype wire

// ==== testbench/pic_cpu_model.sv ====
// Behavioural processor core that marks instruction boundaries
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model #(
  parameter int unsigned GAP = 4
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic cpu_busy,
  output var  logic cpu_instr_done
);
  int unsigned cnt_reg;
  // Boundaries pause while the call and jump sequence owns the core
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg        <= 0;
      cpu_instr_done <= 1'b0;
    end else begin
      cnt_reg        <= (cpu_busy || cnt_reg + 1 >= GAP) ? 0 : cnt_reg + 1;
      cpu_instr_done <= !cpu_busy && (cnt_reg + 1 >= GAP);
    end
  end
endmodule // pic_cpu_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pic_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  avs_address = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, cpu_instr_done, cpu_busy, cpu_global_ie, cpu_irq_pending;
  logic        cpu_ei = 1'b0;
  logic        cpu_di = 1'b0;
  logic        cpu_reti = 1'b0;
  logic [15:0] cpu_fetch_addr;
  logic        cpu_vector_call, cpu_isr_start, transfer_complete_flag, usb_addr_clear;
  logic [15:0] gpio_pin = 16'hFFFF;
  logic        cap_a_pin = 1'b0;
  logic        cap_b_pin = 1'b1;
  logic        spi_byte_done = 1'b0;
  logic [7:0]  spi_rx_byte = 8'h00;
  logic [2:0]  ep_event = 3'h0;
  logic        usb_dp = 1'b0;
  logic        usb_dm = 1'b1;
  logic        ps2_serial_data_line = 1'b1;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [31:0] q;
  logic [15:0] vt [7] = '{16'h0002, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010,
                          16'h0012};

  always #10 core_clk = ~core_clk;

  pic_ctrl #(.T128_CYCLES(16'h0008), .T1MS_CYCLES(16'h0040), .WAKE_CYCLES(16'h0010))
  pic_ctrl_inst (.core_clk, .rst_b, .avs_address, .avs_byteenable, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_instr_done, .cpu_ei, .cpu_di,
    .cpu_reti, .cpu_busy, .cpu_global_ie, .cpu_irq_pending, .cpu_fetch_addr,
    .cpu_vector_call, .cpu_isr_start, .gpio_pin, .cap_a_pin, .cap_b_pin, .spi_byte_done,
    .spi_rx_byte, .transfer_complete_flag, .ep_event, .usb_dp, .usb_dm,
    .ps2_serial_data_line, .usb_addr_clear);

  pic_cpu_model pic_cpu_model_inst (.core_clk, .rst_b, .cpu_busy, .cpu_instr_done);

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      close_out();
    end
  endtask

  function automatic logic [9:0] ra(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    tmo(n, 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic service(input logic [15:0] va);
    int n;
    @(posedge core_clk);
    cpu_ei <= 1'b1;
    @(posedge core_clk);
    cpu_ei <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cpu_busy !== 1'b1 && n < 60);
    tmo(n, 60);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cpu_vector_call !== 1'b1 && n < 30);
    chk("call cycles", n, 10);
    chk("vector", {16'h0, cpu_fetch_addr}, {16'h0, va});
    chk("gie at call", {31'h0, cpu_global_ie}, 0);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cpu_isr_start !== 1'b1 && n < 30);
    chk("jump cycles", n, 5);
    chk("busy at start", {31'h0, cpu_busy}, 0);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    chk("fetch after reset", {16'h0, cpu_fetch_addr}, 0);
    chk("gie after reset", {31'h0, cpu_global_ie}, 0);
    bus(0, ra(IDX_GSE), 0);
    chk("gse reset", q, 0);
    bus(0, ra(IDX_EPE), 0);
    chk("epe reset", q, 0);
    bus(1, 10'h081, 8'hFF);
    bus(0, ra(IDX_GSE), 0);
    chk("unaligned write", q, 0);
    bus(0, ra(8'h30), 0);
    chk("unmapped read", q, 0);
    bus(1, ra(IDX_GPEN0), 8'h03);
    bus(1, ra(IDX_CTRL), 8'h13);
    @(posedge core_clk);
    ep_event             <= 3'h7;
    spi_byte_done        <= 1'b1;
    spi_rx_byte          <= 8'hA5;
    cap_a_pin            <= 1'b1;
    cap_b_pin            <= 1'b0;
    gpio_pin[0]          <= 1'b0;
    ps2_serial_data_line <= 1'b0;
    @(posedge core_clk);
    ep_event      <= 3'h0;
    spi_byte_done <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk("addr clear held", {31'h0, usb_addr_clear}, 1);
    chk("masked request", {31'h0, cpu_irq_pending}, 0);
    ps2_serial_data_line <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("addr clear end", {31'h0, usb_addr_clear}, 0);
    bus(0, ra(IDX_PEND_LO), 0);
    chk("pending lo", q, 32'h0000_00F9);
    bus(0, ra(IDX_PEND_HI), 0);
    chk("pending hi", q, 32'h0000_0001);
    bus(0, ra(IDX_STAT), 0);
    chk("tcf set", q[0], 1);
    chk("tcf pin", {31'h0, transfer_complete_flag}, 1);
    bus(0, ra(IDX_SPI), 0);
    chk("spi byte", q, 32'h0000_00A5);
    bus(0, ra(IDX_STAT), 0);
    chk("tcf cleared", q[0], 0);
    bus(1, ra(IDX_EPE), 8'hFF);
    bus(0, ra(IDX_EPE), 0);
    chk("epe mixed", q, 32'h0000_0007);
    bus(1, ra(IDX_GSE), 8'h39);
    bus(0, ra(IDX_GSE), 0);
    chk("gse readback", q, 32'h0000_0039);
    foreach (vt[i]) service(vt[i]);
    chk("gpio gated", {31'h0, cpu_irq_pending}, 0);
    bus(1, ra(IDX_CTRL), 8'h00);
    usb_dm <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk("addr clear se0", {31'h0, usb_addr_clear}, 1);
    bus(0, ra(IDX_PEND_LO), 0);
    chk("no bus irq in se0", q, 0);
    usb_dm <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(0, ra(IDX_PEND_LO), 0);
    chk("bus irq after se0", q, 32'h0000_0001);
    service(16'h0002);
    bus(1, ra(IDX_GSE), 8'h79);
    // Pin 0 went low while the global GPIO enable was off, so give it a fresh edge
    gpio_pin[0] <= 1'b1;
    @(posedge core_clk);
    gpio_pin[0] <= 1'b0;
    service(16'h0014);
    @(posedge core_clk);
    gpio_pin[1] <= 1'b0;
    repeat (6) @(posedge core_clk);
    bus(0, ra(IDX_PEND_HI), 0);
    chk("pin blocked", q, 0);
    gpio_pin <= 16'hFFFF;
    repeat (4) @(posedge core_clk);
    gpio_pin[0] <= 1'b0;
    repeat (6) @(posedge core_clk);
    bus(0, ra(IDX_PEND_HI), 0);
    chk("pin enable kept", q, 32'h0000_0002);
    bus(1, ra(IDX_GSE), 8'h06);
    repeat (80) @(posedge core_clk);
    bus(0, ra(IDX_PEND_LO), 0);
    chk("timer ticks", q & 32'h6, 32'h6);
    service(16'h0004);
    bus(1, ra(IDX_GSE), 8'h80);
    repeat (40) @(posedge core_clk);
    bus(0, ra(IDX_PEND_HI), 0);
    chk("wake tick", q[2], 1);
    service(16'h0016);
    close_out();
  end
endmodule // tb
`default_nettype wire
